// ===== pkg/pwr_seq_pkg.sv
package pwr_seq_pkg;

    // Register offsets of the plain register port
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] DEBOUNCE_OFS = 4'h1;
    localparam logic [3:0] SHORT_OFS = 4'h2;
    localparam logic [3:0] LONG_OFS = 4'h3;
    localparam logic [3:0] GUARD_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h5;
    localparam logic [3:0] CMD_OFS = 4'h6;

    // Control register fields
    localparam int CTRL_WAIT_KEY_BIT = 0;
    localparam int CTRL_TAMPER_OUT_EN_BIT = 1;
    localparam int CTRL_TAMPER_LEVEL_BIT = 2;

    // Command register fields, write-one pulses
    localparam int CMD_SUSPEND_BIT = 0;
    localparam int CMD_POWER_OFF_BIT = 1;
    localparam int CMD_CANCEL_BIT = 2;
    localparam int CMD_WAKE_BIT = 3;
    localparam int CMD_SUSPEND_ACK_BIT = 4;
    localparam int CMD_OFF_ACK_BIT = 5;
    localparam int CMD_TAMPER_ACK_BIT = 6;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_SUSPEND_IRQ_BIT = 2;
    localparam int STAT_OFF_IRQ_BIT = 3;
    localparam int STAT_GUARD_BIT = 4;
    localparam int STAT_BUTTON_BIT = 5;
    localparam int STAT_VIN_BIT = 6;
    localparam int STAT_TAMPER_BIT = 7;
    localparam int STAT_TAMPER_COUNT_LSB = 8;

    // Reset values, counts in core clock cycles
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] DEBOUNCE_RESET = 32'h0000_0100;
    localparam logic [31:0] SHORT_RESET = 32'h0000_1000;
    localparam logic [31:0] LONG_RESET = 32'h0001_0000;
    localparam logic [31:0] GUARD_RESET = 32'h0010_0000;

    typedef enum logic [1:0]
    {
        PS_RUN,
        PS_OFF,
        PS_SUSPEND,
        PS_COIN
    } power_state_t;

    typedef struct packed
    {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed
    {
        logic pmic_standby;
        logic pmic_off;
        logic mem_self_refresh;
        logic host_reset_n;
        logic power_indicator_out;
    } power_ctrl_t;

endpackage

// ===== logic/power_state_manager.sv
`timescale 1ns/10ps

// Function
// - Exactly one of run, off, suspend, coin-cell
// - Start-on-power option enters run immediately
// - Wait-for-key option waits for button press
// - Power-on or system reset enters run
// - Host reset released while running
// - Power indicator high while running
// - Suspend requests standby and memory self-refresh
// - Suspend keeps wake sources, outputs hold
// - Power-off enters off, commands regulators off
// - Off drives indicator low, wake stays
// - Coin-cell records tampers, drives tamper output
// - Coin-cell power-on when input voltage returns
// - Button active low, wakes suspend and off, not coin-cell
// - Programmable debounce before press evaluation
// - Short press raises suspend interrupt
// - Long press raises power-off interrupt
// - Guard timer forces off on expiry
// - Host cancel abandons forced power-off
// - Input loss switches to coin-cell
// - Voltage detect sampled as synchronous digital level
module power_state_manager
#(
    parameter int CNT_W = 32,
    parameter int TAMPER_CNT_W = 8
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire pwr_seq_pkg::reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    // Field pins
    input wire logic power_button_in,
    input wire logic input_voltage_detect,
    input wire logic system_reset_req,
    input wire logic tamper_in,
    // Power control to PMIC, memory and host
    output pwr_seq_pkg::power_ctrl_t power_ctrl,
    output logic suspend_irq,
    output logic power_off_irq,
    output logic tamper_out,
    output logic [1:0] power_state
);

    // Counters must hold the largest reset count
    if (CNT_W < 21 || CNT_W > 32 || TAMPER_CNT_W < 1 || TAMPER_CNT_W > 24)
    begin : g_param_check
        $error("power_state_manager: unsupported parameter values");
    end

    pwr_seq_pkg::power_state_t state_q;
    logic [31:0] ctrl_q;
    logic [CNT_W-1:0] debounce_len_q;
    logic [CNT_W-1:0] short_len_q;
    logic [CNT_W-1:0] long_len_q;
    logic [CNT_W-1:0] guard_len_q;
    logic [CNT_W-1:0] deb_cnt_q;
    logic [CNT_W-1:0] press_cnt_q;
    logic [CNT_W-1:0] guard_cnt_q;
    logic btn_raw_q;
    logic btn_pressed_q;
    logic vin_q;
    logic short_done_q;
    logic long_done_q;
    logic guard_run_q;
    logic tamper_seen_q;
    logic [TAMPER_CNT_W-1:0] tamper_cnt_q;
    logic tamper_in_q;
    logic started_q;

    logic wr_cmd;
    logic cmd_suspend;
    logic cmd_off;
    logic cmd_cancel;
    logic cmd_wake;
    logic short_hit;
    logic long_hit;
    logic guard_expire;
    logic off_event;
    logic press_event;
    logic tamper_event;
    logic run_d;

    assign wr_cmd = reg_req.wr && reg_req.addr == pwr_seq_pkg::CMD_OFS;
    assign cmd_suspend = wr_cmd && reg_req.wdata[pwr_seq_pkg::CMD_SUSPEND_BIT];
    assign cmd_off = wr_cmd && reg_req.wdata[pwr_seq_pkg::CMD_POWER_OFF_BIT];
    assign cmd_cancel = wr_cmd && reg_req.wdata[pwr_seq_pkg::CMD_CANCEL_BIT];
    assign cmd_wake = wr_cmd && reg_req.wdata[pwr_seq_pkg::CMD_WAKE_BIT];

    // Registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl_q <= pwr_seq_pkg::CTRL_RESET;
            debounce_len_q <= CNT_W'(pwr_seq_pkg::DEBOUNCE_RESET);
            short_len_q <= CNT_W'(pwr_seq_pkg::SHORT_RESET);
            long_len_q <= CNT_W'(pwr_seq_pkg::LONG_RESET);
            guard_len_q <= CNT_W'(pwr_seq_pkg::GUARD_RESET);
        end
        else if (reg_req.wr)
        begin
            case (reg_req.addr)
                pwr_seq_pkg::CTRL_OFS: ctrl_q <= reg_req.wdata;
                pwr_seq_pkg::DEBOUNCE_OFS: debounce_len_q <= reg_req.wdata[CNT_W-1:0];
                pwr_seq_pkg::SHORT_OFS: short_len_q <= reg_req.wdata[CNT_W-1:0];
                // Long press must stay beyond short press
                pwr_seq_pkg::LONG_OFS:
                begin
                    if (reg_req.wdata[CNT_W-1:0] > short_len_q)
                        long_len_q <= reg_req.wdata[CNT_W-1:0];
                end
                pwr_seq_pkg::GUARD_OFS: guard_len_q <= reg_req.wdata[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge core_clk)
    begin
        if (rst)
            reg_rdata <= 32'h0000_0000;
        else if (reg_req.rd)
        begin
            case (reg_req.addr)
                pwr_seq_pkg::CTRL_OFS: reg_rdata <= ctrl_q;
                pwr_seq_pkg::DEBOUNCE_OFS: reg_rdata <= 32'(debounce_len_q);
                pwr_seq_pkg::SHORT_OFS: reg_rdata <= 32'(short_len_q);
                pwr_seq_pkg::LONG_OFS: reg_rdata <= 32'(long_len_q);
                pwr_seq_pkg::GUARD_OFS: reg_rdata <= 32'(guard_len_q);
                pwr_seq_pkg::STATUS_OFS:
                begin
                    reg_rdata <= 32'h0000_0000;
                    reg_rdata[pwr_seq_pkg::STAT_STATE_LSB +: 2] <= state_q;
                    reg_rdata[pwr_seq_pkg::STAT_SUSPEND_IRQ_BIT] <= suspend_irq;
                    reg_rdata[pwr_seq_pkg::STAT_OFF_IRQ_BIT] <= power_off_irq;
                    reg_rdata[pwr_seq_pkg::STAT_GUARD_BIT] <= guard_run_q;
                    reg_rdata[pwr_seq_pkg::STAT_BUTTON_BIT] <= btn_pressed_q;
                    reg_rdata[pwr_seq_pkg::STAT_VIN_BIT] <= vin_q;
                    reg_rdata[pwr_seq_pkg::STAT_TAMPER_BIT] <= tamper_seen_q;
                    reg_rdata[pwr_seq_pkg::STAT_TAMPER_COUNT_LSB +: TAMPER_CNT_W] <= tamper_cnt_q;
                end
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

    // Detect line is already a clean digital level in this clock's domain
    always_ff @(posedge core_clk)
    begin
        if (rst)
            vin_q <= 1'b1;
        else
            vin_q <= input_voltage_detect;
    end

    // Debounce: the raw level must stay put for the whole length
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            btn_raw_q <= 1'b0;
            btn_pressed_q <= 1'b0;
            deb_cnt_q <= '0;
        end
        else
        begin
            btn_raw_q <= !power_button_in;
            if (btn_raw_q == btn_pressed_q)
                deb_cnt_q <= '0;
            else if (deb_cnt_q >= debounce_len_q)
            begin
                btn_pressed_q <= btn_raw_q;
                deb_cnt_q <= '0;
            end
            else
                deb_cnt_q <= deb_cnt_q + 1'b1;
        end
    end

    assign press_event = btn_pressed_q && press_cnt_q == '0;
    assign short_hit = btn_pressed_q && !short_done_q && press_cnt_q == short_len_q;
    assign long_hit = btn_pressed_q && !long_done_q && press_cnt_q == long_len_q;

    // Press timing, each interval fires once per assertion
    always_ff @(posedge core_clk)
    begin
        if (rst || !btn_pressed_q)
        begin
            press_cnt_q <= '0;
            short_done_q <= 1'b0;
            long_done_q <= 1'b0;
        end
        else
        begin
            if (press_cnt_q != '1)
                press_cnt_q <= press_cnt_q + 1'b1;
            if (short_hit)
                short_done_q <= 1'b1;
            if (long_hit)
                long_done_q <= 1'b1;
        end
    end

    // Host interrupts are levels, acknowledged through the command register
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            suspend_irq <= 1'b0;
            power_off_irq <= 1'b0;
        end
        else
        begin
            if (long_hit)
            begin
                power_off_irq <= 1'b1;
                suspend_irq <= 1'b0;
            end
            else
            begin
                if (short_hit && state_q == pwr_seq_pkg::PS_RUN && !power_off_irq)
                    suspend_irq <= 1'b1;
                else if (wr_cmd && reg_req.wdata[pwr_seq_pkg::CMD_SUSPEND_ACK_BIT])
                    suspend_irq <= 1'b0;
                if (wr_cmd && reg_req.wdata[pwr_seq_pkg::CMD_OFF_ACK_BIT])
                    power_off_irq <= 1'b0;
            end
        end
    end

    assign guard_expire = guard_run_q && guard_cnt_q >= guard_len_q && state_q == pwr_seq_pkg::PS_RUN;

    // Guard timer: a new long press restarts it even over a cancel
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            guard_run_q <= 1'b0;
            guard_cnt_q <= '0;
        end
        else if (long_hit && state_q == pwr_seq_pkg::PS_RUN)
        begin
            guard_run_q <= 1'b1;
            guard_cnt_q <= '0;
        end
        else if (cmd_cancel || state_q != pwr_seq_pkg::PS_RUN)
        begin
            guard_run_q <= 1'b0;
            guard_cnt_q <= '0;
        end
        else if (guard_run_q)
            guard_cnt_q <= guard_cnt_q + 1'b1;
    end

    assign off_event = cmd_off || guard_expire;

    // Power state machine
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state_q <= pwr_seq_pkg::PS_OFF;
            started_q <= 1'b0;
        end
        else if (!vin_q)
            state_q <= pwr_seq_pkg::PS_COIN;
        else
        begin
            started_q <= 1'b1;
            case (state_q)
                pwr_seq_pkg::PS_RUN:
                begin
                    if (off_event)
                        state_q <= pwr_seq_pkg::PS_OFF;
                    else if (cmd_suspend)
                        state_q <= pwr_seq_pkg::PS_SUSPEND;
                end
                pwr_seq_pkg::PS_SUSPEND:
                begin
                    if (press_event || cmd_wake || system_reset_req)
                        state_q <= pwr_seq_pkg::PS_RUN;
                end
                pwr_seq_pkg::PS_OFF:
                begin
                    if (!started_q && !ctrl_q[pwr_seq_pkg::CTRL_WAIT_KEY_BIT])
                        state_q <= pwr_seq_pkg::PS_RUN;
                    else if (press_event || cmd_wake || system_reset_req)
                        state_q <= pwr_seq_pkg::PS_RUN;
                end
                pwr_seq_pkg::PS_COIN:
                begin
                    // Input back: power-on event, start option applies again
                    state_q <= pwr_seq_pkg::PS_OFF;
                    started_q <= 1'b0;
                end
                default: state_q <= pwr_seq_pkg::PS_OFF;
            endcase
        end
    end

    assign run_d = state_q == pwr_seq_pkg::PS_RUN;

    // Outputs decoded from the single state register
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            power_ctrl <= '0;
            power_ctrl.pmic_off <= 1'b1;
            power_state <= 2'(pwr_seq_pkg::PS_OFF);
        end
        else
        begin
            power_state <= state_q;
            power_ctrl.host_reset_n <= run_d;
            power_ctrl.power_indicator_out <= run_d;
            power_ctrl.pmic_standby <= state_q == pwr_seq_pkg::PS_SUSPEND;
            power_ctrl.mem_self_refresh <= state_q == pwr_seq_pkg::PS_SUSPEND;
            power_ctrl.pmic_off <= state_q == pwr_seq_pkg::PS_OFF
                || state_q == pwr_seq_pkg::PS_COIN;
        end
    end

    assign tamper_event = (tamper_in == ctrl_q[pwr_seq_pkg::CTRL_TAMPER_LEVEL_BIT]) && !tamper_in_q;

    // Tamper watch runs in every state; set beats acknowledge
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tamper_in_q <= 1'b0;
            tamper_seen_q <= 1'b0;
            tamper_cnt_q <= '0;
            tamper_out <= 1'b0;
        end
        else
        begin
            tamper_in_q <= tamper_in == ctrl_q[pwr_seq_pkg::CTRL_TAMPER_LEVEL_BIT];
            if (tamper_event)
            begin
                tamper_seen_q <= 1'b1;
                if (tamper_cnt_q != '1)
                    tamper_cnt_q <= tamper_cnt_q + 1'b1;
            end
            else if (wr_cmd && reg_req.wdata[pwr_seq_pkg::CMD_TAMPER_ACK_BIT])
                tamper_seen_q <= 1'b0;
            tamper_out <= ctrl_q[pwr_seq_pkg::CTRL_TAMPER_OUT_EN_BIT]
                && (tamper_seen_q || tamper_event);
        end
    end

    // Checks
    a_indicator_run: assert property (@(posedge core_clk) disable iff (rst)
        power_ctrl.power_indicator_out == (power_state == 2'(pwr_seq_pkg::PS_RUN)))
        else $error("indicator does not follow run state");
    a_reset_release: assert property (@(posedge core_clk) disable iff (rst)
        power_ctrl.host_reset_n == (power_state == 2'(pwr_seq_pkg::PS_RUN)))
        else $error("host reset not released in run");
    a_suspend_standby: assert property (@(posedge core_clk) disable iff (rst)
        state_q == pwr_seq_pkg::PS_SUSPEND |=> power_ctrl.pmic_standby && power_ctrl.mem_self_refresh)
        else $error("suspend without standby");
    a_vin_loss: assert property (@(posedge core_clk) disable iff (rst)
        !vin_q |=> state_q == pwr_seq_pkg::PS_COIN)
        else $error("input loss not followed by coin cell");
    a_guard_force: assert property (@(posedge core_clk) disable iff (rst)
        guard_expire && vin_q |=> state_q == pwr_seq_pkg::PS_OFF)
        else $error("guard expiry did not force off");
    a_cancel_stops: assert property (@(posedge core_clk) disable iff (rst)
        cmd_cancel && !long_hit |=> !guard_run_q)
        else $error("cancel did not stop guard");
    a_long_once: assert property (@(posedge core_clk) disable iff (rst)
        long_hit |=> !long_hit [*8])
        else $error("second power-off interrupt in one press");
    a_long_wins: assert property (@(posedge core_clk) disable iff (rst)
        long_hit |=> power_off_irq && !suspend_irq)
        else $error("power-off not taking precedence");
    a_off_guard_clear: assert property (@(posedge core_clk) disable iff (rst)
        state_q == pwr_seq_pkg::PS_OFF |=> !guard_run_q)
        else $error("guard running in off");
    a_short_irq: assert property (@(posedge core_clk) disable iff (rst)
        short_hit && run_d && !power_off_irq && !long_hit |=> suspend_irq)
        else $error("short press gave no suspend interrupt");

    c_short_press: cover property (@(posedge core_clk) disable iff (rst) short_hit);
    c_forced_off: cover property (@(posedge core_clk) disable iff (rst) guard_expire);
    c_coin_return: cover property (@(posedge core_clk) disable iff (rst)
        state_q == pwr_seq_pkg::PS_COIN ##1 state_q == pwr_seq_pkg::PS_OFF);
    c_suspend_wake: cover property (@(posedge core_clk) disable iff (rst)
        state_q == pwr_seq_pkg::PS_SUSPEND ##1 state_q == pwr_seq_pkg::PS_RUN);

endmodule

// ===== verif/power_field_model.sv
`timescale 1ns/10ps

module power_field_model
(
    // Bench commands
    input wire logic press,
    input wire logic supply_ok,
    // Field pins
    output logic power_button_in,
    output logic input_voltage_detect
);
    // No pull-up inside the block, so a released button sits at the external pull-up level
    assign power_button_in = ~press;
    // Detector is a comparator with a clean logic output, never a mid-rail value
    assign input_voltage_detect = supply_ok;
endmodule

// ===== verif/testbench.sv
`timescale 1ns/10ps

module testbench;
    localparam int P_SUSP = 0;
    localparam int P_OFFI = 1;
    localparam int P_TAMP = 2;
    localparam int P_RUN = 4;
    localparam int P_OFF = 5;
    localparam int P_SUS = 6;
    localparam int P_COIN = 7;
    localparam int W_RST = 0;
    localparam int W_PRESS = 1;
    localparam int W_SRST = 2;
    localparam int W_SUPPLY = 3;
    localparam int W_TAMP = 4;
    logic core_clk;
    logic rst;
    pwr_seq_pkg::reg_req_t reg_req;
    logic [31:0] reg_rdata;
    logic power_button_in;
    logic input_voltage_detect;
    logic system_reset_req;
    logic tamper_in;
    pwr_seq_pkg::power_ctrl_t power_ctrl;
    logic suspend_irq;
    logic power_off_irq;
    logic tamper_out;
    logic [1:0] power_state;
    logic press;
    logic supply_ok;
    logic rd_seen;
    logic [63:0] note;
    logic [63:0] exp_q[$];
    logic [31:0] rnd;
    // Short counts keep the run brief: debounce, short, long, guard
    logic [31:0] cnt [4] = '{32'h4, 32'h14, 32'h28, 32'h1e};
    logic [31:0] dflt [5] = '{pwr_seq_pkg::CTRL_RESET, pwr_seq_pkg::DEBOUNCE_RESET,
        pwr_seq_pkg::SHORT_RESET, pwr_seq_pkg::LONG_RESET, pwr_seq_pkg::GUARD_RESET};
    int bad_count;
    int n_checks;
    int cyc = 0;
    int n;

    power_state_manager u_dut (.core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .power_button_in(power_button_in), .input_voltage_detect(input_voltage_detect),
        .system_reset_req(system_reset_req), .tamper_in(tamper_in), .power_ctrl(power_ctrl),
        .suspend_irq(suspend_irq), .power_off_irq(power_off_irq), .tamper_out(tamper_out),
        .power_state(power_state));

    power_field_model u_field (.press(press), .supply_ok(supply_ok), .power_button_in(power_button_in),
        .input_voltage_detect(input_voltage_detect));

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    function automatic logic probe(input int k);
        case (k)
            P_SUSP: probe = suspend_irq;
            P_OFFI: probe = power_off_irq;
            P_TAMP: probe = tamper_out;
            default: probe = (power_state == 2'(k - 4));
        endcase
    endfunction

    // Counts cycles to the event in n, then lets the lagging outputs land
    task automatic wait_on(input int k, input int lim);
        n = 0;
        while (probe(k) !== 1'b1 && n < lim)
        begin
            @(negedge core_clk);
            n++;
        end
        repeat (2) @(negedge core_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
        exp_q.push_back({mask, exp});
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req.rd <= 1'b0;
    endtask

    task automatic cmd(input int b);
        wr(pwr_seq_pkg::CMD_OFS, 32'h1 << b);
    endtask

    // Selector instead of a ref argument, so the pin update stays a plain non-blocking assignment
    task automatic drive(input int w, input logic v);
        @(posedge core_clk);
        case (w)
            W_RST: rst <= v;
            W_PRESS: press <= v;
            W_SRST: system_reset_req <= v;
            W_SUPPLY: supply_ok <= v;
            default: tamper_in <= v;
        endcase
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge core_clk)
    begin
        rd_seen <= reg_req.rd;
    end

    always @(negedge core_clk)
    begin
        if (rd_seen === 1'b1)
        begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : 64'hffff_ffff_dead_beef;
            chk(reg_rdata & note[63:32], note[31:0]);
        end
    end

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count++;
            results();
        end
    end

    initial
    begin
        rst = 1'b1;
        reg_req = '0;
        press = 1'b0;
        supply_ok = 1'b1;
        system_reset_req = 1'b0;
        tamper_in = 1'b1;
        rnd = 32'h3f;
        repeat (15) @(posedge core_clk);
        @(negedge core_clk);
        chk(power_state, pwr_seq_pkg::PS_OFF);
        chk(power_ctrl.pmic_off, 1'b1);
        drive(W_RST, 1'b0);
        wait_on(P_RUN, 10);
        chk(probe(P_RUN), 1'b1);
        chk(power_ctrl.host_reset_n, 1'b1);
        chk(power_ctrl.power_indicator_out, 1'b1);
        for (int i = 0; i < 5; i++)
            rd(4'(i), 32'hffff_ffff, dflt[i]);
        rd(4'hf, 32'hffff_ffff, 32'h0);
        rd(pwr_seq_pkg::STATUS_OFS, 32'h43, 32'h40);
        for (int i = 0; i < 4; i++)
            wr(4'(i + 1), cnt[i]);
        // A long interval not above the short one must be refused
        wr(pwr_seq_pkg::LONG_OFS, 32'ha);
        for (int i = 0; i < 4; i++)
            rd(4'(i + 1), 32'hffff_ffff, cnt[i]);
        for (int i = 0; i < 8; i++)
        begin
            rnd = xs(rnd);
            drive(W_PRESS, 1'b1);
            repeat (1 + rnd % 3) @(posedge core_clk);
            press <= 1'b0;
            repeat (8) @(posedge core_clk);
        end
        rd(pwr_seq_pkg::STATUS_OFS, 32'h2c, 32'h0);
        drive(W_PRESS, 1'b1);
        wait_on(P_SUSP, 40);
        chk(n >= 24 && n <= 32, 1'b1);
        drive(W_PRESS, 1'b0);
        repeat (40) @(negedge core_clk);
        chk(power_off_irq, 1'b0);
        cmd(pwr_seq_pkg::CMD_SUSPEND_ACK_BIT);
        repeat (2) @(negedge core_clk);
        chk(suspend_irq, 1'b0);
        drive(W_PRESS, 1'b1);
        wait_on(P_OFFI, 80);
        chk(n >= 44, 1'b1);
        chk(suspend_irq, 1'b0);
        drive(W_PRESS, 1'b0);
        rd(pwr_seq_pkg::STATUS_OFS, 32'h18, 32'h18);
        wait_on(P_OFF, 40);
        chk(probe(P_OFF), 1'b1);
        chk(power_ctrl.pmic_off, 1'b1);
        chk(power_ctrl.power_indicator_out, 1'b0);
        cmd(pwr_seq_pkg::CMD_OFF_ACK_BIT);
        rd(pwr_seq_pkg::STATUS_OFS, 32'h18, 32'h0);
        drive(W_SRST, 1'b1);
        drive(W_SRST, 1'b0);
        wait_on(P_RUN, 10);
        chk(probe(P_RUN), 1'b1);
        drive(W_PRESS, 1'b1);
        wait_on(P_OFFI, 80);
        drive(W_PRESS, 1'b0);
        // Host backs out of the forced power-off well inside the guard time
        cmd(pwr_seq_pkg::CMD_CANCEL_BIT);
        repeat (50) @(negedge core_clk);
        chk(probe(P_RUN), 1'b1);
        cmd(pwr_seq_pkg::CMD_OFF_ACK_BIT);
        cmd(pwr_seq_pkg::CMD_SUSPEND_BIT);
        wait_on(P_SUS, 5);
        chk(power_ctrl.pmic_standby, 1'b1);
        chk(power_ctrl.mem_self_refresh, 1'b1);
        drive(W_PRESS, 1'b1);
        wait_on(P_RUN, 20);
        chk(probe(P_RUN), 1'b1);
        drive(W_PRESS, 1'b0);
        repeat (10) @(posedge core_clk);
        cmd(pwr_seq_pkg::CMD_POWER_OFF_BIT);
        wait_on(P_OFF, 5);
        chk(probe(P_OFF), 1'b1);
        cmd(pwr_seq_pkg::CMD_WAKE_BIT);
        wait_on(P_RUN, 5);
        chk(probe(P_RUN), 1'b1);
        wr(pwr_seq_pkg::CTRL_OFS, 32'h3);
        drive(W_SUPPLY, 1'b0);
        wait_on(P_COIN, 6);
        chk(probe(P_COIN), 1'b1);
        drive(W_TAMP, 1'b0);
        drive(W_TAMP, 1'b1);
        wait_on(P_TAMP, 10);
        chk(tamper_out, 1'b1);
        rd(pwr_seq_pkg::STATUS_OFS, 32'hff80, 32'h0180);
        drive(W_SUPPLY, 1'b1);
        wait_on(P_OFF, 6);
        chk(probe(P_OFF), 1'b1);
        repeat (30) @(negedge core_clk);
        chk(power_state, pwr_seq_pkg::PS_OFF);
        drive(W_PRESS, 1'b1);
        wait_on(P_RUN, 20);
        chk(probe(P_RUN), 1'b1);
        drive(W_PRESS, 1'b0);
        cmd(pwr_seq_pkg::CMD_TAMPER_ACK_BIT);
        repeat (3) @(negedge core_clk);
        chk(tamper_out, 1'b0);
        // Active level turned high while the pin sits high: one more event, output disabled
        wr(pwr_seq_pkg::CTRL_OFS, 32'h5);
        repeat (3) @(negedge core_clk);
        chk(tamper_out, 1'b0);
        rd(pwr_seq_pkg::STATUS_OFS, 32'hff80, 32'h0280);
        repeat (2) @(negedge core_clk);
        results();
    end
endmodule
